// [pkg/cbac_defines.svh]
// Constants of the card bus arbitration controller: register offsets,
// field positions, reset values and timing counts.
// Assumes inclusion by bare name from the design file and the testbench.
`ifndef CBAC_DEFINES_SVH
`define CBAC_DEFINES_SVH

// ============================================================
// Register offsets (byte addresses)
`define CBAC_OFS_BUS_CONTROL_ONE 8'h00
`define CBAC_OFS_BUS_CONTROL_TWO 8'h04
`define CBAC_OFS_CARD_TIMING 8'h08
`define CBAC_OFS_WAIT_CONTROL_ONE 8'h0C
`define CBAC_OFS_WAIT_CONTROL_TWO 8'h10
`define CBAC_OFS_STATUS 8'h14

// ============================================================
// Field positions in bus_control_one
`define CBAC_B1_AREA5_CARD 0
`define CBAC_B1_AREA6_CARD 1
`define CBAC_B1_AREA5_BURST 2
`define CBAC_B1_AREA6_BURST 4
`define CBAC_B1_ADDR_PULLUP 6
`define CBAC_B1_DATA_PULLUP 7
`define CBAC_B1_ATTR_SELECT 8
// Field positions in bus_control_two (width: 01 = 8 bit, 10 = 16 bit)
`define CBAC_B2_AREA5_WIDTH 0
`define CBAC_B2_AREA6_WIDTH 2
// Field positions in card_timing_control
`define CBAC_PT_AREA5_SETUP 0
`define CBAC_PT_AREA5_HOLD 2
`define CBAC_PT_AREA6_SETUP 4
`define CBAC_PT_AREA6_HOLD 6
// Field positions in wait_control_two (three-bit software waits)
`define CBAC_W2_AREA5_WAIT 0
`define CBAC_W2_AREA6_WAIT 3

// ============================================================
// Reset values
`define CBAC_RST_BUS_CONTROL_ONE 16'h0000
`define CBAC_RST_BUS_CONTROL_TWO 16'h000A
`define CBAC_RST_CARD_TIMING 16'h0000
`define CBAC_RST_WAIT_CONTROL_ONE 16'hFFFF
`define CBAC_RST_WAIT_CONTROL_TWO 16'h003F

// ============================================================
// Timing
`define CBAC_CLK_PERIOD_NS 10
`define CBAC_ADDR_PULLUP_CLOCKS 4
`define CBAC_WIDTH_16 2'h2

`endif

// [pkg/cbac_pkg.sv]
// Types of the card bus arbitration controller.
// Assumes nothing beyond a SystemVerilog compiler.
package cbac_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_GAP,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_GRANT
    } cbac_state_t;

    // Access request from the core side
    typedef struct packed {
        logic valid;
        logic [28:0] addr;
        logic write;
        logic [1:0] size;
        logic [31:0] wdata;
        logic no_wait;
        logic locked;
    } cbac_req_t;

    // Card bus pins driven by the device
    typedef struct packed {
        logic [25:0] addr;
        logic [15:0] data;
        logic data_oe_n;
        logic area5_chip_select_n;
        logic area6_chip_select_n;
        logic area5_upper_enable_n;
        logic area6_upper_enable_n;
        logic rd_n;
        logic we_n;
        logic card_io_cycle;
        logic attr_select_n;
    } cbac_pins_t;

endpackage

// [verification/cbac_card_model.sv]
// Card on the far side: answers reads from the address, may stall.
// Assumes the controller's pin struct and one clock.
module cbac_card_model
    import cbac_pkg::*;
(
    input wire logic ref_clk,
    input cbac_pkg::cbac_pins_t pins,
    input wire logic slow,
    input wire logic narrow,
    input wire logic big_endian,
    output logic [15:0] card_data_in,
    output logic ext_wait_n,
    output logic io_width_sense_n
);
    logic [15:0] last_r;
    logic [1:0] stall_r;
    logic strobe;
    // ==========
    // Read data
    assign strobe = !(pins.rd_n && pins.we_n);
    // Released data lines show the inverse of the last value
    assign card_data_in = pins.rd_n ? ~last_r : {pins.addr[7:0] ^ 8'hA5, pins.addr[7:0]};
    assign ext_wait_n = !(slow && strobe && stall_r != 2'h2);
    assign io_width_sense_n = big_endian ? 1'b0 : narrow;
    always_ff @(posedge ref_clk) begin
        last_r <= card_data_in;
        stall_r <= !strobe ? 2'h0 : (stall_r == 2'h2 ? stall_r : stall_r + 2'h1);
    end
endmodule

// [verification/tb_cbac_ctrl.sv]
// Bench of the card bus controller: register and access tasks with checks.
// Assumes the card model on the far side and the defines header.
`include "cbac_defines.svh"
module tb_cbac_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import cbac_pkg::*;
    logic ref_clk, rst_n, reg_wr, reg_rd, req_ready, acc_done, rd_valid;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, card_data_in;
    logic [31:0] rd_data;
    logic big_endian, ext_wait_n, io_sense_n, brq_n, grant_n, rereq_n;
    logic refresh_pending, refresh_start, apu, dpu, slow, narrow, io_seen;
    logic [3:0] irq_level, mask;
    cbac_req_t req;
    cbac_pins_t pins;
    int bad_count, check_count, n, f, lsame, lx;
    cbac_ctrl i_cbac_ctrl (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .req(req), .req_ready(req_ready), .acc_done(acc_done), .rd_valid(rd_valid),
        .rd_data(rd_data), .big_endian(big_endian), .card_data_in(card_data_in),
        .ext_wait_n(ext_wait_n), .io_width_sense_n(io_sense_n), .pins(pins),
        .bus_release_request_n(brq_n), .bus_grant_n(grant_n), .bus_rerequest_n(rereq_n),
        .refresh_pending(refresh_pending), .refresh_start(refresh_start),
        .irq_level(irq_level), .interrupt_mask_field(mask), .addr_pullup_on(apu),
        .data_pullup_on(dpu));
    cbac_card_model i_cbac_card_model (.ref_clk(ref_clk), .pins(pins), .slow(slow),
        .narrow(narrow), .big_endian(big_endian), .card_data_in(card_data_in),
        .ext_wait_n(ext_wait_n), .io_width_sense_n(io_sense_n));
    // ==========
    // Tasks
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string nm);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        chk(nm, {16'h0, reg_rdata}, {16'h0, e});
    endtask
    // Word access; n counts cycles to completion, f counts read strobes
    task automatic acc(input logic [28:0] a, input logic w, output int n, output int f);
        logic p;
        p = 1'b1;
        n = 0;
        f = 0;
        @(posedge ref_clk);
        req <= '{1'b1, a, w, 2'h1, 32'h0000A55A, 1'b0, 1'b0};
        do begin
            @(posedge ref_clk);
            if (req.valid === 1'b1 && req_ready === 1'b1) req.valid <= 1'b0;
            if (pins.rd_n === 1'b0 && p) f++;
            if (pins.rd_n === 1'b0 || pins.we_n === 1'b0) io_seen = pins.card_io_cycle;
            p = pins.rd_n;
            n++;
        end while (acc_done !== 1'b1 && n < 80);
        if (n >= 80) begin
            bad_count++;
            tally_and_finish();
        end
        chk("rd_valid", {31'h0, rd_valid}, {31'h0, !w});
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // ==========
    // Main sequence
    initial begin
        logic [28:0] ta [4];
        logic te [4];
        int k, np, lrw, lww;
        ta = '{29'h14000010, 29'h17FFFFF0, 29'h18000010, 29'h1A000000};
        te = '{1'b0, 1'b1, 1'b0, 1'b1};
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, big_endian, slow, narrow} = '0;
        {refresh_pending, refresh_start, irq_level, io_seen} = '0;
        req = '0;
        brq_n = 1'b1;
        mask = 4'h3;
        bad_count = 0;
        check_count = 0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`CBAC_OFS_BUS_CONTROL_TWO, `CBAC_RST_BUS_CONTROL_TWO, "width");
        rd(`CBAC_OFS_WAIT_CONTROL_ONE, `CBAC_RST_WAIT_CONTROL_ONE, "idle");
        rd(8'h40, 16'h0000, "unmapped");
        wr(`CBAC_OFS_BUS_CONTROL_ONE, 16'h00C3);
        rd(`CBAC_OFS_BUS_CONTROL_ONE, 16'h00C3, "ctl_one");
        for (k = 0; k < 4; k++) begin
            acc(ta[k], 1'b0, n, f);
            chk("io_cycle", {31'h0, io_seen}, {31'h0, te[k]});
            chk("rd_data", rd_data & 32'hFFFF, {16'h0, ta[k][7:0] ^ 8'hA5, ta[k][7:0]});
        end
        acc(29'h1A000010, 1'b1, lrw, f);
        acc(29'h1A000010, 1'b1, lww, f);
        chk("rw_idle", 32'(lrw > lww), 32'h1);
        acc(29'h14000010, 1'b0, lx, f);
        acc(29'h14000010, 1'b0, lsame, f);
        chk("area_idle", 32'(lx > lsame), 32'h1);
        wr(`CBAC_OFS_WAIT_CONTROL_ONE, 16'h0000);
        acc(29'h18000010, 1'b0, lx, f);
        chk("idle_zero", 32'(lx), 32'(lsame));
        wr(`CBAC_OFS_WAIT_CONTROL_ONE, 16'hFFFF);
        wr(`CBAC_OFS_WAIT_CONTROL_TWO, 16'h0000);
        acc(29'h18000010, 1'b0, np, f);
        slow <= 1'b1;
        acc(29'h18000010, 1'b0, lx, f);
        chk("wait_pin", 32'(lx), 32'(np + 2));
        slow <= 1'b0;
        wr(`CBAC_OFS_WAIT_CONTROL_TWO, `CBAC_RST_WAIT_CONTROL_TWO);
        narrow <= 1'b1;
        acc(29'h16000020, 1'b0, n, f);
        chk("split", 32'(f), 32'h2);
        acc(29'h14000020, 1'b0, n, f);
        chk("no_split", 32'(f), 32'h1);
        big_endian <= 1'b1;
        acc(29'h16000020, 1'b0, n, f);
        chk("big_io", 32'(f), 32'h1);
        {big_endian, narrow} <= 2'b00;
        brq_n <= 1'b0;
        np = 0;
        repeat (16) begin
            @(posedge ref_clk);
            if (apu === 1'b1) np++;
        end
        chk("grant", {31'h0, grant_n}, 32'h0);
        chk("pullup", 32'(np), 32'h4);
        chk("ready", {31'h0, req_ready}, 32'h0);
        chk("dpu", {31'h0, dpu}, 32'h1);
        refresh_pending <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("rereq", {31'h0, rereq_n}, 32'h0);
        refresh_pending <= 1'b0;
        refresh_start <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("rereq", {31'h0, rereq_n}, 32'h1);
        refresh_start <= 1'b0;
        irq_level <= 4'h5;
        repeat (3) @(posedge ref_clk);
        chk("rereq", {31'h0, rereq_n}, 32'h0);
        irq_level <= 4'h0;
        brq_n <= 1'b1;
        acc(29'h18000010, 1'b0, lx, f);
        chk("grant", {31'h0, grant_n}, 32'h1);
        chk("arb_idle", 32'(lx), 32'(lsame));
        tally_and_finish();
    end
endmodule

// [verilog/cbac_ctrl.sv]
// Card bus controller for areas 5 and 6 with idle insertion and arbitration.
// Assumes the request and pin inputs are synchronous to ref_clk.
//
// Functional notes
// - Card-select bits put areas 5/6 on card bus
// - Card areas run 8 or 16 bits wide
// - Ignore wait input for flagged DMA/writeback accesses
// - Every card-area access is a card cycle
// - Programmable setup, hold, software and pin waits
// - Nonzero burst field bursts card memory reads only
// - A24 may select attribute memory
// - Area 5 upper range gives I/O cycles
// - Area 6 upper range gives I/O cycles
// - Width sense high splits little-endian word I/O in two
// - Idle cycles on area change or read-then-write
// - No idle between same-area writes or same-area reads
// - Two-bit idle count per area 0, 2-6
// - Empty cycles reduce inserted idle count
// - No idle cycles after bus arbitration
// - Finish cycle, release bus, then grant
// - No release within split sequences; req.locked is not used
// - Request removed: drop grant, resume
// - Re-request output asks master to return bus
// - Re-request on pending refresh or unmasked interrupt
// - Address pull-up 4 clocks; data pull-up idle
// - Refresh start negates re-request unless an unmasked interrupt is pending
//
// Decided for this implementation: the address map and the plain strobed port.
`include "cbac_defines.svh"

module cbac_ctrl (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input cbac_pkg::cbac_req_t req,
    output logic req_ready,
    output logic acc_done,
    output logic rd_valid,
    output logic [31:0] rd_data,
    input wire logic big_endian,
    input wire logic [15:0] card_data_in,
    input wire logic ext_wait_n,
    input wire logic io_width_sense_n,
    output cbac_pkg::cbac_pins_t pins,
    input wire logic bus_release_request_n,
    output logic bus_grant_n,
    output logic bus_rerequest_n,
    input wire logic refresh_pending,
    input wire logic refresh_start,
    input wire logic [3:0] irq_level,
    input wire logic [3:0] interrupt_mask_field,
    output logic addr_pullup_on,
    output logic data_pullup_on
);
    import cbac_pkg::*;

    typedef struct packed {
        cbac_state_t state;
        logic [15:0] bc1;
        logic [15:0] bc2;
        logic [15:0] card_timing_control;
        logic [15:0] wc1;
        logic [15:0] wc2;
        logic [15:0] rdata;
        logic [2:0] last_area;
        logic last_wr;
        logic have_last;
        logic [1:0] empty;
        logic after_arb;
        logic [2:0] cnt;
        logic [1:0] part;
        logic [1:0] last_part;
        logic eight;
        logic [3:0] beat;
        logic burst;
        logic [28:0] addr;
        logic [31:0] wdata;
        logic write;
        logic [1:0] size;
        logic no_wait;
        logic [31:0] rbuf;
        logic done;
        logic rvalid;
        logic grant;
        logic rereq;
        logic [2:0] apu;
        cbac_pins_t pins;
    } cbac_regs_t;

    cbac_regs_t st_r;
    cbac_regs_t st_nxt;

    // ============================================================
    // Decoding helpers
    function automatic logic [1:0] idle_of(input logic [15:0] wc, input logic [2:0] area);
        idle_of = (area == 3'd1 || area == 3'd7) ? 2'd0 : wc[{area, 1'b0} +: 2];
    endfunction

    function automatic logic is_card(input logic [15:0] bc, input logic [2:0] area);
        is_card = (area == 3'd5) ? bc[`CBAC_B1_AREA5_CARD] :
                  (area == 3'd6) ? bc[`CBAC_B1_AREA6_CARD] : 1'b0;
    endfunction

    function automatic logic [1:0] fld2(input logic [15:0] r, input logic [2:0] area,
                                        input int p5, input int p6);
        fld2 = (area == 3'd5) ? r[p5 +: 2] : (area == 3'd6) ? r[p6 +: 2] : 2'd0;
    endfunction

    logic [2:0] cur_area;
    logic [2:0] req_area;
    logic cur_w16;
    logic [2:0] sw_wait;
    logic [1:0] burst_fld;
    logic [1:0] need_idle;
    logic [28:0] part_addr;

    assign cur_area = st_r.addr[28:26];
    assign req_area = req.addr[28:26];
    assign cur_w16 = !is_card(st_r.bc1, cur_area) ||
        (fld2(st_r.bc2, cur_area, `CBAC_B2_AREA5_WIDTH, `CBAC_B2_AREA6_WIDTH)
         == `CBAC_WIDTH_16);
    assign sw_wait = (cur_area == 3'd5) ? st_r.wc2[`CBAC_W2_AREA5_WAIT +: 3] :
                     (cur_area == 3'd6) ? st_r.wc2[`CBAC_W2_AREA6_WAIT +: 3] : 3'd0;
    assign burst_fld = fld2(st_r.bc1, cur_area, `CBAC_B1_AREA5_BURST, `CBAC_B1_AREA6_BURST);
    assign part_addr = st_r.addr + ((cur_w16 && !st_r.eight) ?
        29'({st_r.part, 1'b0}) : 29'(st_r.part)) +
        29'(cur_w16 ? {st_r.beat, 1'b0} : {1'b0, st_r.beat});

    // Idle cycles owed before the request at the port
    always_comb begin
        need_idle = 2'd0;
        if (st_r.have_last && !st_r.after_arb &&
            (req_area != st_r.last_area || (req.write && !st_r.last_wr))) begin
            need_idle = idle_of(st_r.wc1, st_r.last_area);
        end
        need_idle = (need_idle > st_r.empty) ? need_idle - st_r.empty : 2'd0;
    end

    // ============================================================
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        st_nxt.rvalid = 1'b0;
        // Register port
        if (reg_wr) begin
            case (reg_addr)
                `CBAC_OFS_BUS_CONTROL_ONE: st_nxt.bc1 = reg_wdata;
                `CBAC_OFS_BUS_CONTROL_TWO: st_nxt.bc2 = reg_wdata;
                `CBAC_OFS_CARD_TIMING: st_nxt.card_timing_control = reg_wdata;
                `CBAC_OFS_WAIT_CONTROL_ONE: st_nxt.wc1 = reg_wdata;
                `CBAC_OFS_WAIT_CONTROL_TWO: st_nxt.wc2 = reg_wdata;
                default: st_nxt.bc1 = st_r.bc1;
            endcase
        end
        st_nxt.rdata = 16'h0000;
        if (reg_rd) begin
            case (reg_addr)
                `CBAC_OFS_BUS_CONTROL_ONE: st_nxt.rdata = st_r.bc1;
                `CBAC_OFS_BUS_CONTROL_TWO: st_nxt.rdata = st_r.bc2;
                `CBAC_OFS_CARD_TIMING: st_nxt.rdata = st_r.card_timing_control;
                `CBAC_OFS_WAIT_CONTROL_ONE: st_nxt.rdata = st_r.wc1;
                `CBAC_OFS_WAIT_CONTROL_TWO: st_nxt.rdata = st_r.wc2;
                `CBAC_OFS_STATUS: st_nxt.rdata = {8'h00, st_r.last_area, st_r.last_wr,
                    st_r.grant, st_r.rereq, st_r.state != ST_IDLE, st_r.after_arb};
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
        // Re-request whenever the core needs the bus back
        st_nxt.rereq = (refresh_pending && !refresh_start) ||
                       (irq_level > interrupt_mask_field);
        st_nxt.apu = (st_r.apu != 3'd0) ? st_r.apu - 3'd1 : 3'd0;
        st_nxt.pins.rd_n = 1'b1;
        st_nxt.pins.we_n = 1'b1;
        st_nxt.pins.data_oe_n = 1'b1;

        case (st_r.state)
            ST_IDLE: begin
                st_nxt.pins.area5_chip_select_n = 1'b1;
                st_nxt.pins.area6_chip_select_n = 1'b1;
                st_nxt.pins.area5_upper_enable_n = 1'b1;
                st_nxt.pins.area6_upper_enable_n = 1'b1;
                st_nxt.empty = (st_r.empty == 2'd3) ? 2'd3 : st_r.empty + 2'd1;
                if (!bus_release_request_n) begin
                    st_nxt.state = ST_GRANT;
                    st_nxt.grant = 1'b1;
                    st_nxt.apu = st_r.bc1[`CBAC_B1_ADDR_PULLUP] ?
                        3'(`CBAC_ADDR_PULLUP_CLOCKS) : 3'd0;
                end else if (req.valid) begin
                    st_nxt.addr = req.addr;
                    st_nxt.wdata = req.wdata;
                    st_nxt.write = req.write;
                    st_nxt.size = req.size;
                    st_nxt.no_wait = req.no_wait;
                    st_nxt.rbuf = 32'h0000_0000;
                    st_nxt.part = 2'd0;
                    st_nxt.beat = 4'd0;
                    st_nxt.eight = 1'b0;
                    // A gap loads the idle count, a direct start the setup count
                    st_nxt.cnt = (need_idle != 2'd0) ? {1'b0, need_idle} :
                        {1'b0, fld2(st_r.card_timing_control, req_area, `CBAC_PT_AREA5_SETUP,
                                    `CBAC_PT_AREA6_SETUP)};
                    st_nxt.state = (need_idle != 2'd0) ? ST_GAP : ST_SETUP;
                end
            end
            ST_GAP: begin
                st_nxt.cnt = st_r.cnt - 3'd1;
                if (st_r.cnt == 3'd1) begin
                    st_nxt.state = ST_SETUP;
                    st_nxt.cnt = {1'b0, fld2(st_r.card_timing_control, cur_area, `CBAC_PT_AREA5_SETUP,
                                             `CBAC_PT_AREA6_SETUP)};
                end
            end
            ST_SETUP: begin
                if (st_r.part == 2'd0 && st_r.beat == 4'd0) begin
                    // Access shape fixed on entry
                    st_nxt.last_part = cur_w16 ? ((st_r.size == 2'd2) ? 2'd1 : 2'd0) :
                        ((st_r.size == 2'd2) ? 2'd3 : (st_r.size == 2'd1) ? 2'd1 : 2'd0);
                    st_nxt.burst = is_card(st_r.bc1, cur_area) && !st_r.write &&
                                   !st_r.addr[25] && burst_fld != 2'd0;
                end
                st_nxt.pins.addr = part_addr[25:0];
                st_nxt.pins.attr_select_n = !(st_r.bc1[`CBAC_B1_ATTR_SELECT] &&
                                              !part_addr[24]);
                st_nxt.pins.card_io_cycle = is_card(st_r.bc1, cur_area) &&
                                            st_r.addr[25];
                st_nxt.pins.area5_chip_select_n = !(cur_area == 3'd5);
                st_nxt.pins.area6_chip_select_n = !(cur_area == 3'd6);
                st_nxt.pins.area5_upper_enable_n = !(cur_area == 3'd5 && cur_w16 && !st_r.eight);
                st_nxt.pins.area6_upper_enable_n = !(cur_area == 3'd6 && cur_w16 && !st_r.eight);
                st_nxt.pins.data = (cur_w16 && !st_r.eight) ? st_r.wdata[{st_r.part[0], 4'h0} +: 16]
                    : {8'h00, st_r.wdata[{st_r.part, 3'h0} +: 8]};
                st_nxt.pins.data_oe_n = !st_r.write;
                if (st_r.cnt == 3'd0) begin
                    st_nxt.state = ST_STROBE;
                    st_nxt.cnt = sw_wait;
                end else begin
                    st_nxt.cnt = st_r.cnt - 3'd1;
                end
            end
            ST_STROBE: begin
                st_nxt.pins.rd_n = st_r.write;
                st_nxt.pins.we_n = !st_r.write;
                st_nxt.pins.data_oe_n = !st_r.write;
                if (st_r.cnt != 3'd0) begin
                    st_nxt.cnt = st_r.cnt - 3'd1;
                end else if ((ext_wait_n || st_r.no_wait) &&
                             !(st_r.pins.rd_n && st_r.pins.we_n)) begin
                    // Data and wait pin count only once the strobe is on the pins
                    if (cur_w16 && !st_r.eight) begin
                        st_nxt.rbuf[{st_r.part[0], 4'h0} +: 16] = card_data_in;
                    end else begin
                        st_nxt.rbuf[{st_r.part, 3'h0} +: 8] = card_data_in[7:0];
                    end
                    // Width sense high on a little-endian 16-bit word I/O cycle: finish in bytes
                    if (st_r.part == 2'd0 && st_r.pins.card_io_cycle && !big_endian &&
                        cur_w16 && st_r.size == 2'd1 && io_width_sense_n) begin
                        st_nxt.eight = 1'b1;
                        st_nxt.last_part = 2'd1;
                        st_nxt.rbuf[15:8] = 8'h00;
                    end
                    st_nxt.state = ST_HOLD;
                    st_nxt.cnt = {1'b0, fld2(st_r.card_timing_control, cur_area, `CBAC_PT_AREA5_HOLD,
                                             `CBAC_PT_AREA6_HOLD)};
                    if (st_r.burst) begin
                        st_nxt.rvalid = 1'b1;
                        st_nxt.rbuf = {16'h0000, card_data_in};
                        if (st_r.beat != ((4'd4 << burst_fld[1]) - 4'd1 + {3'd0, &burst_fld} * 4'd8)) begin
                            // Page mode: strobe stays low, only address moves
                            st_nxt.beat = st_r.beat + 4'd1;
                            st_nxt.state = ST_STROBE;
                            st_nxt.cnt = sw_wait;
                            st_nxt.pins.addr = st_r.pins.addr + 26'(cur_w16 ? 2 : 1);
                        end
                    end
                end
            end
            ST_HOLD: begin
                st_nxt.pins.data_oe_n = !st_r.write;
                if (st_r.cnt != 3'd0) begin
                    st_nxt.cnt = st_r.cnt - 3'd1;
                end else if (st_r.part != st_r.last_part && !st_r.burst) begin
                    st_nxt.part = st_r.part + 2'd1;
                    st_nxt.state = ST_SETUP;
                    st_nxt.cnt = {1'b0, fld2(st_r.card_timing_control, cur_area, `CBAC_PT_AREA5_SETUP,
                                             `CBAC_PT_AREA6_SETUP)};
                end else begin
                    st_nxt.done = 1'b1;
                    st_nxt.rvalid = !st_r.write && !st_r.burst;
                    st_nxt.state = ST_IDLE;
                    st_nxt.last_area = cur_area;
                    st_nxt.last_wr = st_r.write;
                    st_nxt.have_last = 1'b1;
                    st_nxt.after_arb = 1'b0;
                    st_nxt.empty = 2'd0;
                end
            end
            ST_GRANT: begin
                if (bus_release_request_n) begin
                    st_nxt.grant = 1'b0;
                    st_nxt.after_arb = 1'b1;
                    st_nxt.state = ST_IDLE;
                end
            end
            default: st_nxt.state = ST_IDLE;
        endcase
    end

    // ============================================================
    // State register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.state <= ST_IDLE;
            st_r.bc1 <= `CBAC_RST_BUS_CONTROL_ONE;
            st_r.bc2 <= `CBAC_RST_BUS_CONTROL_TWO;
            st_r.card_timing_control <= `CBAC_RST_CARD_TIMING;
            st_r.wc1 <= `CBAC_RST_WAIT_CONTROL_ONE;
            st_r.wc2 <= `CBAC_RST_WAIT_CONTROL_TWO;
            st_r.pins <= '1;
            st_r.pins.addr <= 26'h0000000;
            st_r.pins.data <= 16'h0000;
            st_r.pins.card_io_cycle <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ============================================================
    // Outputs
    assign reg_rdata = st_r.rdata;
    assign req_ready = (st_r.state == ST_IDLE) && bus_release_request_n;
    assign acc_done = st_r.done;
    assign rd_valid = st_r.rvalid;
    assign rd_data = st_r.rbuf;
    assign pins = st_r.pins;
    assign bus_grant_n = !st_r.grant;
    assign bus_rerequest_n = !st_r.rereq;
    assign addr_pullup_on = st_r.grant && (st_r.apu != 3'd0);
    assign data_pullup_on = st_r.bc1[`CBAC_B1_DATA_PULLUP] && st_r.pins.data_oe_n &&
                            (st_r.state == ST_IDLE || st_r.state == ST_GAP ||
                             st_r.state == ST_GRANT);

    // ============================================================
    // Checks
    sequence grant_rise_s;
        $rose(st_r.grant) && st_r.bc1[`CBAC_B1_ADDR_PULLUP];
    endsequence

    sequence held_request_s;
        !bus_release_request_n [*3];
    endsequence

    sequence pullup_tail_s;
        $past(addr_pullup_on) && addr_pullup_on ##1 addr_pullup_on ##1 !addr_pullup_on;
    endsequence

    AST_GRANT_FROM_IDLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        $fell(bus_grant_n) |-> $past(st_r.state) == ST_IDLE)
        else $error("grant asserted while a bus cycle was running");
    AST_GRANT_DROP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (!bus_grant_n && bus_release_request_n) |=> bus_grant_n)
        else $error("grant held after release request removed");
    AST_REREQ_SET: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (refresh_pending && !refresh_start) |=> !bus_rerequest_n)
        else $error("re-request missing for pending refresh");
    AST_REREQ_CLR: assert property (@(posedge ref_clk) disable iff (!rst_n)
        ((!refresh_pending || refresh_start) && irq_level <= interrupt_mask_field)
        |=> bus_rerequest_n)
        else $error("re-request not negated");
    AST_ADDR_PULLUP_START: assert property (@(posedge ref_clk) disable iff (!rst_n)
        grant_rise_s |-> addr_pullup_on)
        else $error("address pull-up missing at grant");
    AST_ADDR_PULLUP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        grant_rise_s ##0 held_request_s |-> pullup_tail_s)
        else $error("address pull-up not four clocks");
    AST_NO_SPLIT_RELEASE: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_r.state inside {ST_SETUP, ST_STROBE, ST_HOLD}) |=> (st_r.state != ST_GRANT))
        else $error("bus released inside an access");
    AST_DATA_PULLUP: assert property (@(posedge ref_clk) disable iff (!rst_n)
        data_pullup_on |-> pins.data_oe_n && pins.we_n)
        else $error("data pull-up while data bus driven");
    AST_IO_AREA5: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_r.state == ST_SETUP && cur_area == 3'd5 && st_r.bc1[0] && st_r.addr[25])
        |=> pins.card_io_cycle)
        else $error("area 5 I/O range not an I/O cycle");
    AST_NO_IDLE_WW: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_r.state == ST_IDLE && req.valid && bus_release_request_n && req.write &&
         st_r.last_wr && req_area == st_r.last_area) |=> st_r.state == ST_SETUP)
        else $error("idle inserted between writes");
    AST_BURST_READ_ONLY: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (st_r.state == ST_STROBE && st_r.write) |-> !st_r.burst)
        else $error("write performed as burst");

endmodule
